// ===== vrss_sequencer.sv
// Purpose: Soft-start, phase-state and fault sequencer of a dual-rail buck controller
// Assumes: Analog comparators give digital flags; on-chip ADC gives the current configuration
// Notes: Enable low returns every state to off, clearing the over-current, overvoltage and ramp undervoltage latches
//
// Summary of operation
// - Ramp supply undervoltage is acted on only while enabled.
// - Driver supply fault forces all gates and the driver enable line low.
// - Gates and driver enable stay low for a minimum hold time.
// - After driver fault, modulators return to mid and soft start restarts.
// - Counter steps reference code from zero to target at fixed slew.
// - Modulators float while test current captures max-current configuration.
// - After capture, modulators go to mid level meaning diode mode.
// - Driver enable and compensation release precede the reference ramp.
// - Each phase leaves mid level only at its first modulation pulse.
// - Total limit normally; per-phase fixed limit below 0.25 V code.
// - 100% limit flag held for 50 us shuts down.
// - 150% limit flag shuts down immediately.
// - Over-current shutdown latches until enable goes low.
// - Shed limit is one third for three phases, half for two.
// - Full phase state uses full limit; shed states use reduced limit.
// - Output 300 mV below reference drops rail ready.
// - Overvoltage forces low gates high and modulators low.
// - After overvoltage reference ramps to zero; driver enable stays high.
// - Overvoltage latch clears only by enable going low.
// - Fixed 1.75 V overvoltage threshold during soft start and voltage change.
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module vrss_sequencer import vrss_pkg::*; (
  // AHB-Lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Analog flags and enable pin
  input wire logic enable_pin,
  input wire logic ramp_supply_uv,
  input wire logic driver_power_fail,
  input wire logic ocp_total_100,
  input wire logic ocp_total_150,
  input wire logic ocp_phase,
  input wire logic uv_core,
  input wire logic uv_aux,
  input wire logic ovp_ref_rel,
  input wire logic ovp_fixed,
  // Modulator and ADC side
  input wire logic [NCORE+NAUX-1:0] pwm_pulse,
  input wire logic [7:0] core_max_current_cfg,
  input wire logic [7:0] aux_max_current_cfg,
  // Modulator states and drivers
  output logic [2*NCORE-1:0] core_modulator_out,
  output logic [2*NAUX-1:0] aux_modulator_out,
  output logic high_gate_one,
  output logic high_gate_two,
  output logic high_gate_aux,
  output logic low_gate_one,
  output logic low_gate_two,
  output logic low_gate_aux,
  output logic driver_enable_out,
  output logic driver_enable_line,
  // Control towards analog
  output logic comp_release,
  output logic test_current_en,
  output logic [7:0] ref_code,
  output logic per_phase_limit_sel,
  output logic [1:0] core_current_limit_sense_scale,
  output logic [1:0] aux_current_limit_sense_scale,
  output logic ovp_fixed_sel,
  output logic phase_sync,
  output logic core_rail_ready,
  output logic aux_rail_ready
);
  localparam int NPH = NCORE + NAUX;

  // ==========================================================
  // Flag synchronisation
  vrss_flags_t fl;
  vrss_sync #(.W(10)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din({enable_pin, ramp_supply_uv, driver_power_fail, ocp_total_100, ocp_total_150,
          ocp_phase, uv_core, uv_aux, ovp_ref_rel, ovp_fixed}),
    .dout(fl)
  );

  // ==========================================================
  // Functions
  function automatic logic [1:0] phase_code(input vrss_state_t s, input logic first,
                                            input logic pulse);
    logic [1:0] c;
    c = MOD_HIZ;
    case (s)
      ST_MID, ST_DRV_HOLD: c = MOD_MID;
      ST_RAMP, ST_RUN: c = !(first || pulse) ? MOD_MID : (pulse ? MOD_HIGH : MOD_LOW);
      ST_OVP_DN, ST_OVP_HOLD, ST_OCP_OFF: c = MOD_LOW;
      default: c = MOD_HIZ;
    endcase
    return c;
  endfunction

  function automatic logic [4:0] clamp_div(input logic [31:0] w);
    logic [4:0] v;
    v = (w[31:5] != '0) ? DIV_MAX : w[4:0];
    if (v < DIV_MIN) v = DIV_MIN;
    if (v > DIV_MAX) v = DIV_MAX;
    return v;
  endfunction

  // ==========================================================
  // Registers
  vrss_state_t st_q, st_d;
  logic [11:0] tmr_q, tmr_d;
  logic [11:0] ocp_cnt_q, ocp_cnt_d;
  logic [7:0] ref_q, ref_d;
  logic [7:0] tgt_q;
  logic full_q;
  logic [4:0] div_q;
  logic [4:0] osc_cnt_q;
  logic [3:0] ph_cnt_q;
  logic [7:0] cfg_core_q, cfg_aux_q;
  logic ocp_lat_q, ovp_lat_q, drv_lat_q, uv_lat_q;
  logic [NPH-1:0] first_q;
  logic [2*NPH-1:0] mod_q, mod_d;
  logic hg_one_q, hg_two_q, hg_aux_q, lg_one_q, lg_two_q, lg_aux_q;
  logic drv_en_q, drv_line_q, comp_q, test_q, lim_sel_q, ovp_sel_q, sync_q;
  logic [1:0] core_scl_q, aux_scl_q;
  logic core_rdy_q, aux_rdy_q;
  logic wr_q;
  logic [7:0] wa_q;
  logic [31:0] rdata_q;

  // ==========================================================
  // Sequencer decode
  logic active, ramping, dynamic_voltage_change, slew_tick, tmr_done, low_code, ocp_lvl, ocp_to, ovp_trip;
  logic restart, drv_on_d, osc_tick;
  assign active = (st_q == ST_MID) || (st_q == ST_RAMP) || (st_q == ST_RUN);
  assign ramping = (st_q == ST_RAMP) || (st_q == ST_RUN) || (st_q == ST_OVP_DN);
  assign dynamic_voltage_change = (st_q == ST_RUN) && (ref_q != tgt_q);
  assign slew_tick = ramping && (tmr_q == 12'(SLEW_CYC - 1));
  assign tmr_done = (st_q == ST_CAPT) ? (tmr_q == 12'(CAPT_CYC - 1))
                                      : (tmr_q == 12'(HOLD_CYC - 1));
  assign low_code = ref_q < LOW_CODE;
  assign ocp_lvl = low_code ? fl.ocp_ph : fl.ocp100;
  assign ocp_to = ocp_lvl && (ocp_cnt_q == 12'(LATCH_CYC - 1));
  assign ovp_trip = ((st_q == ST_RAMP) || dynamic_voltage_change) ? fl.ovp_fix : fl.ovp_rel;
  assign restart = fl.drv_fail || (fl.en && fl.ramp_uv);
  assign drv_on_d = (st_q == ST_RAMP) || (st_q == ST_RUN) || (st_q == ST_OVP_DN)
                    || (st_q == ST_OVP_HOLD);
  assign osc_tick = (osc_cnt_q == div_q - 5'h01);

  // Next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_OFF: st_d = ST_CAPT;
      ST_CAPT: if (tmr_done) st_d = ST_MID;
      ST_MID: st_d = ST_RAMP;
      ST_RAMP: if (ref_q == tgt_q) st_d = ST_RUN;
      ST_RUN: st_d = ST_RUN;
      ST_OVP_DN: if (ref_q == 8'h00) st_d = ST_OVP_HOLD;
      ST_OVP_HOLD: st_d = ST_OVP_HOLD;
      ST_OCP_OFF: st_d = ST_OCP_OFF;
      ST_DRV_HOLD: if (tmr_done && !restart) st_d = ST_MID;
      default: st_d = ST_OFF;
    endcase
    if (active) begin
      if (restart) st_d = ST_DRV_HOLD;
      else if (ovp_trip) st_d = ST_OVP_DN;
      else if (fl.ocp150 || ocp_to) st_d = ST_OCP_OFF;
    end
    if (!fl.en) st_d = ST_OFF;
  end

  // Timer, latch-off counter, reference slew
  always_comb begin
    tmr_d = (st_d != st_q || slew_tick) ? 12'h000 : (tmr_done ? tmr_q : tmr_q + 12'h001);
    ocp_cnt_d = (active && ocp_lvl && !ocp_to) ? ocp_cnt_q + 12'h001 : 12'h000;
    ref_d = ref_q;
    if (!ramping) ref_d = 8'h00;
    else if (slew_tick && st_q == ST_OVP_DN && ref_q != 8'h00) ref_d = ref_q - 8'h01;
    else if (slew_tick && st_q != ST_OVP_DN && ref_q < tgt_q) ref_d = ref_q + 8'h01;
    else if (slew_tick && st_q != ST_OVP_DN && ref_q > tgt_q) ref_d = ref_q - 8'h01;
  end

  // Per-phase modulator states
  genvar gi;
  generate
    for (gi = 0; gi < NPH; gi++) begin : g_ph
      assign mod_d[2*gi+1:2*gi] = phase_code(st_q, first_q[gi], pwm_pulse[gi]);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          first_q[gi] <= 1'b0;
        end else if (st_q == ST_RAMP || st_q == ST_RUN) begin
          first_q[gi] <= first_q[gi] | pwm_pulse[gi];
        end else begin
          first_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Sequencer state and latched faults
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= ST_OFF;
      tmr_q <= 12'h000;
      ocp_cnt_q <= 12'h000;
      ref_q <= 8'h00;
      ocp_lat_q <= 1'b0;
      ovp_lat_q <= 1'b0;
      drv_lat_q <= 1'b0;
      uv_lat_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      ocp_cnt_q <= ocp_cnt_d;
      ref_q <= ref_d;
      ocp_lat_q <= (st_d == ST_OCP_OFF);
      ovp_lat_q <= (st_d == ST_OVP_DN) || (st_d == ST_OVP_HOLD);
      drv_lat_q <= fl.drv_fail;
      uv_lat_q <= fl.en && fl.ramp_uv;
    end
  end

  // Captured current configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_core_q <= 8'h00;
      cfg_aux_q <= 8'h00;
    end else if (st_q == ST_CAPT && tmr_done) begin
      cfg_core_q <= core_max_current_cfg;
      cfg_aux_q <= aux_max_current_cfg;
    end
  end

  // ==========================================================
  // Driver and analog control outputs
  logic line_d, ovp_st;
  assign line_d = drv_on_d && !fl.drv_fail;
  assign ovp_st = (st_q == ST_OVP_DN) || (st_q == ST_OVP_HOLD);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mod_q <= '0;
      drv_en_q <= 1'b0;
      drv_line_q <= 1'b0;
      hg_one_q <= 1'b0;
      hg_two_q <= 1'b0;
      hg_aux_q <= 1'b0;
      lg_one_q <= 1'b0;
      lg_two_q <= 1'b0;
      lg_aux_q <= 1'b0;
      comp_q <= 1'b0;
      test_q <= 1'b0;
    end else begin
      mod_q <= mod_d;
      drv_en_q <= drv_on_d;
      drv_line_q <= line_d;
      hg_one_q <= line_d && (mod_d[1:0] == MOD_HIGH);
      hg_two_q <= line_d && (mod_d[3:2] == MOD_HIGH);
      hg_aux_q <= line_d && (mod_d[7:6] == MOD_HIGH);
      lg_one_q <= line_d && (ovp_st || mod_d[1:0] == MOD_LOW);
      lg_two_q <= line_d && (ovp_st || mod_d[3:2] == MOD_LOW);
      lg_aux_q <= line_d && (ovp_st || mod_d[7:6] == MOD_LOW);
      comp_q <= (st_q == ST_RAMP) || (st_q == ST_RUN);
      test_q <= (st_q == ST_CAPT);
    end
  end

  // Limits, thresholds, rail ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lim_sel_q <= 1'b1;
      core_scl_q <= SCL_FULL;
      aux_scl_q <= SCL_FULL;
      ovp_sel_q <= 1'b0;
      core_rdy_q <= 1'b0;
      aux_rdy_q <= 1'b0;
    end else begin
      lim_sel_q <= low_code;
      core_scl_q <= full_q ? SCL_FULL : SCL_THIRD;
      aux_scl_q <= full_q ? SCL_FULL : SCL_HALF;
      ovp_sel_q <= (st_q == ST_RAMP) || dynamic_voltage_change;
      core_rdy_q <= (st_q == ST_RUN) && !fl.uv_core;
      aux_rdy_q <= (st_q == ST_RUN) && !fl.uv_aux;
    end
  end

  // Switching frequency divider, master tick then divide by twelve
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_cnt_q <= 5'h00;
      ph_cnt_q <= 4'h0;
      sync_q <= 1'b0;
    end else begin
      osc_cnt_q <= osc_tick ? 5'h00 : osc_cnt_q + 5'h01;
      if (osc_tick) ph_cnt_q <= (ph_cnt_q == 4'(PH_DIV - 1)) ? 4'h0 : ph_cnt_q + 4'h1;
      sync_q <= osc_tick && (ph_cnt_q == 4'(PH_DIV - 1));
    end
  end

  // ==========================================================
  // AHB-Lite slave, zero wait states, always OKAY
  logic a_valid;
  logic [31:0] rd_mux;
  assign a_valid = hsel && htrans[1] && hready;
  assign rd_mux = (haddr[7:0] == OFS_CTRL) ? {23'h0, full_q, tgt_q} :
                  (haddr[7:0] == OFS_FREQ) ? {27'h0, div_q} :
                  (haddr[7:0] == OFS_STAT) ? {16'h0, ref_q, uv_lat_q, drv_lat_q,
                                              ovp_lat_q, ocp_lat_q, st_q} :
                  (haddr[7:0] == OFS_CFG) ? {16'h0, cfg_aux_q, cfg_core_q} : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_q <= a_valid && hwrite && (haddr[31:8] == '0);
      wa_q <= haddr[7:0];
      if (a_valid && !hwrite) rdata_q <= (haddr[31:8] == '0) ? rd_mux : 32'h0000_0000;
    end
  end

  // Writable control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgt_q <= RST_TGT;
      full_q <= RST_FULL;
      div_q <= RST_DIV;
    end else if (wr_q && wa_q == OFS_CTRL) begin
      tgt_q <= hwdata[7:0];
      full_q <= hwdata[CTRL_FULL_BIT];
    end else if (wr_q && wa_q == OFS_FREQ) begin
      div_q <= clamp_div(hwdata);
    end
  end

  // ==========================================================
  // Output ports
  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign core_modulator_out = mod_q[2*NCORE-1:0];
  assign aux_modulator_out = mod_q[2*NPH-1:2*NCORE];
  assign high_gate_one = hg_one_q;
  assign high_gate_two = hg_two_q;
  assign high_gate_aux = hg_aux_q;
  assign low_gate_one = lg_one_q;
  assign low_gate_two = lg_two_q;
  assign low_gate_aux = lg_aux_q;
  assign driver_enable_out = drv_en_q;
  assign driver_enable_line = drv_line_q;
  assign comp_release = comp_q;
  assign test_current_en = test_q;
  assign ref_code = ref_q;
  assign per_phase_limit_sel = lim_sel_q;
  assign core_current_limit_sense_scale = core_scl_q;
  assign aux_current_limit_sense_scale = aux_scl_q;
  assign ovp_fixed_sel = ovp_sel_q;
  assign phase_sync = sync_q;
  assign core_rail_ready = core_rdy_q;
  assign aux_rail_ready = aux_rdy_q;

  // ==========================================================
  // Assertions
  AST_OCP_FAST: assert property (@(posedge hclk) disable iff (!hresetn)
    active && fl.en && !restart && !ovp_trip && fl.ocp150 |=> st_q == ST_OCP_OFF)
    else $error("150 percent limit did not shut down at once");
  AST_OCP_LATCH: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_q == ST_OCP_OFF) |-> $past(fl.ocp150) || $past(ocp_cnt_q) == 12'(LATCH_CYC - 1))
    else $error("over-current shutdown without cause");
  AST_OCP_STAY: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == ST_OCP_OFF && fl.en |=> st_q == ST_OCP_OFF && !drv_en_q)
    else $error("over-current latch left while enabled");
  AST_CAPT_HIZ: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == ST_CAPT |=> mod_q == '0 && test_q)
    else $error("modulators not floating during capture");
  AST_DRV_ORDER: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(drv_en_q) |-> $past(mod_q[1:0]) == MOD_MID && ref_q == 8'h00 && comp_q)
    else $error("driver enable without mid level first");
  AST_DRV_FAIL: assert property (@(posedge hclk) disable iff (!hresetn)
    fl.drv_fail |=> !drv_line_q && !hg_one_q && !lg_one_q && !lg_aux_q)
    else $error("gates not forced low on driver fault");
  AST_HOLD_TIME: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(st_q == ST_DRV_HOLD) && fl.en |-> $past(tmr_q) == 12'(HOLD_CYC - 1))
    else $error("driver fault hold too short");
  AST_UV_READY: assert property (@(posedge hclk) disable iff (!hresetn)
    fl.uv_core |=> !core_rdy_q)
    else $error("rail ready kept under undervoltage");
  AST_OVP_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == ST_OVP_HOLD && fl.en |=> ref_q == 8'h00 && drv_line_q && lg_one_q
    && mod_q[1:0] == MOD_LOW)
    else $error("overvoltage hold outputs wrong");
  AST_EN_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    !fl.en |=> st_q == ST_OFF ##1 !drv_en_q)
    else $error("enable low did not reset sequencer");
endmodule

// ===== vrss_pkg.sv
// Purpose: Shared constants and types of the soft-start and fault sequencer
// Assumes: 40 MHz hclk, 8-bit reference code with 5 mV per step
// Notes: Offsets are byte addresses on the AHB-Lite register port
package vrss_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 40;
  localparam int LATCH_US = 50;
  localparam int LATCH_CYC = LATCH_US * CLK_MHZ;
  localparam int CAPT_NS = 5000;
  localparam int CAPT_CYC = (CAPT_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_NS = 20000;
  localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int SLEW_NS = 250;
  localparam int SLEW_CYC = (SLEW_NS * CLK_MHZ + 999) / 1000;
  localparam int PH_DIV = 12;
  localparam logic [4:0] DIV_MIN = 5'h05;
  localparam logic [4:0] DIV_MAX = 5'h10;
  // ==========================================================
  // Reference code
  localparam int LSB_MV = 5;
  localparam int LOW_MV = 250;
  localparam logic [7:0] LOW_CODE = 8'(LOW_MV / LSB_MV);
  // ==========================================================
  // Register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FREQ = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_CFG = 8'h0C;
  localparam logic [7:0] RST_TGT = 8'h00;
  localparam logic RST_FULL = 1'b1;
  localparam logic [4:0] RST_DIV = 5'h08;
  localparam int CTRL_FULL_BIT = 8;
  // ==========================================================
  // Modulator output codes
  localparam logic [1:0] MOD_HIZ = 2'b00;
  localparam logic [1:0] MOD_MID = 2'b01;
  localparam logic [1:0] MOD_HIGH = 2'b10;
  localparam logic [1:0] MOD_LOW = 2'b11;
  // Current limit scale codes
  localparam logic [1:0] SCL_FULL = 2'b00;
  localparam logic [1:0] SCL_THIRD = 2'b01;
  localparam logic [1:0] SCL_HALF = 2'b10;
  localparam int NCORE = 3;
  localparam int NAUX = 2;
  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ST_OFF = 4'b0000,
    ST_CAPT = 4'b0001,
    ST_MID = 4'b0011,
    ST_RAMP = 4'b0010,
    ST_RUN = 4'b0110,
    ST_OVP_DN = 4'b0111,
    ST_OVP_HOLD = 4'b0101,
    ST_OCP_OFF = 4'b0100,
    ST_DRV_HOLD = 4'b1100
  } vrss_state_t;

  typedef struct packed {
    logic en;
    logic ramp_uv;
    logic drv_fail;
    logic ocp100;
    logic ocp150;
    logic ocp_ph;
    logic uv_core;
    logic uv_aux;
    logic ovp_rel;
    logic ovp_fix;
  } vrss_flags_t;
endpackage

// ===== vrss_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for analog flags
// Assumes: Inputs are asynchronous to hclk
// Notes: Output changes only when stages two and three agree
`timescale 1ns/1ps
module vrss_sync #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Flags
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  // Agreement filter
  assign out_d = (s2_q == s3_q) ? s3_q : out_q;
  assign dout = out_q;

  // Stages
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end
endmodule

// ===== vrss_drv_model.sv
// Purpose: Behavioural gate driver and power stage facing the sequencer
// Assumes: Same clock as the sequencer; the bench commands supply faults
// Notes: Pulses stop whenever the integrated driver enable is low
`timescale 1ns/1ps
module vrss_drv_model import vrss_pkg::*; (
  // Clock
  input wire logic hclk,
  // Controller side
  input wire logic driver_enable_line,
  input wire logic fail_cmd,
  // Driver answers
  output logic driver_power_fail,
  output logic [NCORE+NAUX-1:0] pwm_pulse
);
  int hold_q;
  logic [2:0] tick_q;

  initial begin
    driver_power_fail = 1'b0;
    pwm_pulse = '0;
    hold_q = 0;
    tick_q = 3'h0;
  end

  // ==========================================================
  // Supply fault report, held for the minimum hold time
  always @(posedge hclk) begin
    if (fail_cmd) begin
      hold_q <= HOLD_CYC;
    end else if (hold_q > 0) begin
      hold_q <= hold_q - 1;
    end
    driver_power_fail <= fail_cmd || hold_q > 1;
  end

  // Staggered modulation pulses while the drivers are enabled
  always @(posedge hclk) begin
    tick_q <= tick_q + 3'h1;
    pwm_pulse <= driver_enable_line ? 5'(1 << tick_q) : '0;
  end
endmodule

// ===== tb.sv
// Purpose: Self-checking bench of the soft-start and fault sequencer
// Assumes: Zero-wait AHB-Lite slave; register map as in the package
// Notes: Read results are matched against a queue of expected values
`timescale 1ns/1ps
module tb import vrss_pkg::*;;
  localparam int LIMIT = 20000;
  logic hclk, hresetn, hsel, hwrite, enable_pin, ramp_supply_uv, driver_power_fail;
  logic ocp_total_100, ocp_total_150, ocp_phase, uv_core, uv_aux, ovp_ref_rel, ovp_fixed;
  logic fail_cmd, hreadyout, hresp, high_gate_one, high_gate_two, high_gate_aux;
  logic low_gate_one, low_gate_two, low_gate_aux, driver_enable_out, driver_enable_line;
  logic comp_release, test_current_en, per_phase_limit_sel, ovp_fixed_sel, phase_sync;
  logic core_rail_ready, aux_rail_ready;
  logic [31:0] haddr, hwdata, hrdata, seen;
  logic [1:0] htrans, core_current_limit_sense_scale, aux_current_limit_sense_scale;
  logic [2:0] hsize;
  logic [4:0] pwm_pulse;
  logic [7:0] core_max_current_cfg, aux_max_current_cfg, ref_code, tgt;
  logic [5:0] core_modulator_out;
  logic [3:0] aux_modulator_out;
  logic [31:0] exp_q[$];
  int seed, fails, total_checks, cyc, pulses;
  event got;

  vrss_sequencer dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .enable_pin, .ramp_supply_uv,
    .driver_power_fail, .ocp_total_100, .ocp_total_150, .ocp_phase, .uv_core, .uv_aux,
    .ovp_ref_rel, .ovp_fixed, .pwm_pulse, .core_max_current_cfg, .aux_max_current_cfg,
    .core_modulator_out, .aux_modulator_out, .high_gate_one, .high_gate_two, .high_gate_aux,
    .low_gate_one, .low_gate_two, .low_gate_aux, .driver_enable_out, .driver_enable_line,
    .comp_release, .test_current_en, .ref_code, .per_phase_limit_sel, .core_current_limit_sense_scale,
    .aux_current_limit_sense_scale, .ovp_fixed_sel, .phase_sync, .core_rail_ready, .aux_rail_ready);
  vrss_drv_model drv (.hclk, .driver_enable_line, .fail_cmd, .driver_power_fail, .pwm_pulse);

  // ==========================================================
  // Clock and cycle ceiling
  always #12.5 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      fails++;
      stop_test();
    end
  end

  // Compare one value and count it
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // Oldest expectation against each read result
  always @(got) begin
    check(seen, exp_q.pop_front());
  end

  // One single AHB-Lite transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  // Masked read whose result goes to the watcher
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000, r);
    seen = r & m;
    ->got;
  endtask

  // Poll the state field under a bounded count
  task automatic wait_st(input logic [3:0] st);
    logic [31:0] r;
    int n;
    n = 0;
    r = '1;
    while (r[3:0] !== st && n < 1000) begin
      bus(1'b0, OFS_STAT, 32'h0000_0000, r);
      n++;
    end
    check(r[3:0], st);
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'h5cbfbf03;
    {hclk, hresetn, hsel, hwrite, enable_pin, ramp_supply_uv, fail_cmd} = '0;
    {ocp_total_100, ocp_total_150, ocp_phase, uv_core, uv_aux, ovp_ref_rel, ovp_fixed} = '0;
    {haddr, hwdata, htrans, fails, total_checks, cyc, pulses} = '0;
    hsize = 3'h2;
    core_max_current_cfg = 8'($random(seed));
    aux_max_current_cfg = 8'($random(seed));
    tgt = 8'(($random(seed) & 15) + 2);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(OFS_CTRL, '1, 32'h0000_0100);
    rdc(OFS_FREQ, '1, 32'h0000_0008);
    rdc(8'h40, '1, 32'h0000_0000);
    wr(OFS_FREQ, 32'h0000_001F);
    rdc(OFS_FREQ, '1, 32'h0000_0010);
    wr(OFS_FREQ, 32'h0000_0001);
    rdc(OFS_FREQ, '1, 32'h0000_0005);
    ramp_supply_uv <= 1'b1;
    repeat (8) @(posedge hclk);
    rdc(OFS_STAT, '1, 32'h0000_0000);
    ramp_supply_uv <= 1'b0;
    wr(OFS_CTRL, {23'h00_0000, 1'b1, tgt});
    enable_pin <= 1'b1;
    wait_st(ST_CAPT);
    check(test_current_en, 1'b1);
    check(core_modulator_out, {3{MOD_HIZ}});
    wait_st(ST_RUN);
    rdc(OFS_STAT, '1, {16'h0000, tgt, 8'h06});
    rdc(OFS_CFG, '1, {16'h0000, aux_max_current_cfg, core_max_current_cfg});
    check({driver_enable_out, comp_release, core_rail_ready}, 3'h7);
    check({hresp, core_modulator_out[1:0] == MOD_MID}, 2'h0);
    uv_core <= 1'b1;
    uv_aux <= 1'b1;
    repeat (8) @(posedge hclk);
    check({core_rail_ready, aux_rail_ready}, 2'h0);
    {uv_core, uv_aux} <= 2'b00;
    wr(OFS_CTRL, {23'h00_0000, 1'b0, tgt});
    rdc(OFS_CTRL, '1, {24'h00_0000, tgt});
    check({core_current_limit_sense_scale, aux_current_limit_sense_scale}, {SCL_THIRD, SCL_HALF});
    wr(OFS_CTRL, {23'h00_0000, 1'b1, tgt});
    rdc(OFS_STAT, 32'h0000_000F, 32'h0000_0006);
    check({core_current_limit_sense_scale, aux_current_limit_sense_scale}, {SCL_FULL, SCL_FULL});
    ocp_total_150 <= 1'b1;
    wait_st(ST_OCP_OFF);
    ocp_total_150 <= 1'b0;
    repeat (20) @(posedge hclk);
    rdc(OFS_STAT, 32'h0000_003F, 32'h0000_0014);
    enable_pin <= 1'b0;
    wait_st(ST_OFF);
    rdc(OFS_STAT, 32'h0000_0030, 32'h0000_0000);
    enable_pin <= 1'b1;
    wait_st(ST_RUN);
    tgt = 8'h40;
    wr(OFS_CTRL, {23'h00_0000, 1'b1, tgt});
    repeat (4) @(posedge hclk);
    check({ovp_fixed_sel, per_phase_limit_sel}, 2'h3);
    repeat (700) @(posedge hclk);
    check({ref_code, ovp_fixed_sel, per_phase_limit_sel}, {tgt, 2'h0});
    ocp_total_100 <= 1'b1;
    repeat (1900) @(posedge hclk);
    rdc(OFS_STAT, 32'h0000_000F, 32'h0000_0006);
    wait_st(ST_OCP_OFF);
    ocp_total_100 <= 1'b0;
    enable_pin <= 1'b0;
    wait_st(ST_OFF);
    enable_pin <= 1'b1;
    wait_st(ST_RUN);
    ovp_ref_rel <= 1'b1;
    wait_st(ST_OVP_HOLD);
    ovp_ref_rel <= 1'b0;
    repeat (20) @(posedge hclk);
    rdc(OFS_STAT, 32'h0000_FF3F, 32'h0000_0025);
    check(driver_enable_out, 1'b1);
    check({low_gate_one, low_gate_two, low_gate_aux, core_modulator_out}, {3'h7, {3{MOD_LOW}}});
    enable_pin <= 1'b0;
    wait_st(ST_OFF);
    enable_pin <= 1'b1;
    wait_st(ST_RUN);
    fail_cmd <= 1'b1;
    @(posedge hclk);
    fail_cmd <= 1'b0;
    wait_st(ST_DRV_HOLD);
    check({driver_enable_line, low_gate_one, low_gate_two, low_gate_aux}, 4'h0);
    check({high_gate_one, high_gate_two, high_gate_aux, driver_enable_out}, 4'h0);
    check({core_modulator_out, aux_modulator_out}, {{3{MOD_MID}}, {2{MOD_MID}}});
    wait_st(ST_RUN);
    rdc(OFS_STAT, 32'h0000_FF0F, {16'h0000, tgt, 8'h06});
    // Divider of five gives one sync pulse every sixty cycles
    repeat (120) begin
      @(negedge hclk);
      pulses += phase_sync;
    end
    check(pulses, 32'h0000_0002);
    stop_test();
  end
endmodule
